// ### rtl/adcpp_pkg.sv
/*
 * Shared constants and carrier types of the parallel read/convert port of a
 * 12-bit sampling converter.
 * Assumes a single 250 MHz clock and a synchronous active-high reset.
 */
package adcpp_pkg;

    // Widths of the result word and of the output lane bus.
    localparam int RES_W  = 12;
    localparam int LANE_W = 16;

    // Clock period and the least request hold time, in nanoseconds.
    localparam int CLK_PERIOD_NS = 4;
    localparam int REQ_HOLD_NS   = 40;
    // Least time rounds up to whole cycles.
    localparam int REQ_HOLD_CYC  = (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Default conversion length in internal clock cycles.
    localparam int CONV_CYC_DEF  = 2000;
    localparam int CNT_W         = 16;

    // Reset values.
    localparam logic [RES_W-1:0]  RES_RST  = 12'h000;
    localparam logic [LANE_W-1:0] LANE_RST = 16'h0000;
    localparam logic [3:0]        ZERO4    = 4'h0;

    // Converter states.
    typedef enum logic [0:0] {
        ADCPP_IDLE = 1'b0,
        ADCPP_CONV = 1'b1
    } adcpp_state_t;

    // Control pins as seen after synchronisation.
    typedef struct packed {
        logic cs_n;
        logic rc_n;
        logic byte_sel;
    } adcpp_ctl_t;

    // Driven lane bus with its enable (enable low while driving).
    typedef struct packed {
        logic [LANE_W-1:0] data;
        logic [LANE_W-1:0] oe_n;
    } adcpp_lanes_t;

endpackage : adcpp_pkg

// ### rtl/adcpp_lane_mux.sv
/*
 * Lane mapper: places the 12-bit result on the 16 output lanes in word or
 * swapped-byte order with zero fill.
 * Assumes its inputs are already in the clock domain; purely combinational.
 */
`timescale 1ns/100ps
module adcpp_lane_mux (
    input  wire logic [adcpp_pkg::RES_W-1:0]  result,
    input  wire logic                         byte_sel,
    output logic      [adcpp_pkg::LANE_W-1:0] lanes
);

    // Lane 15 is the first upper pin; lanes 3..0 are the last lower pins.
    always_comb begin
        if (byte_sel) begin
            lanes = {result[3:0], adcpp_pkg::ZERO4, result[11:4]};
        end else begin
            lanes = {result[11:0], adcpp_pkg::ZERO4};
        end
    end

endmodule : adcpp_lane_mux

// ### rtl/adcpp_port.sv
/*
 * Parallel read/convert host port of a 12-bit sampling converter: control
 * pin decoding, conversion timing, busy flag, result register and the
 * three-state output lanes.
 * Assumes pins arrive asynchronously and an analog core supplies a sample
 * word on sample_in that is stable while a conversion runs.
 */
// Notes on behaviour
// - Lanes float unless chip select is low and read/convert is high.
// - Byte select low puts result bits 11..4 on upper lanes, 3..0 on the next four.
// - Byte select low drives the last four lower lanes to zero.
// - Byte select high swaps bytes: bits 3..0 on upper lanes, 11..4 on lower.
// - Byte select high drives the last four upper lanes to zero.
// - With select low, read/convert falling holds the sample and starts a conversion.
// - With select low, read/convert rising enables the outputs.
// - The two controls are ORed, so select falling with read/convert low converts.
// - Select falling with read/convert high enables outputs without converting.
// - Busy is low from conversion start until the result is latched.
// - New data is on the lanes by the time busy rises.
// - If both controls are low as busy rises, a new conversion starts at once.
// - Requests arriving while busy is low are ignored.
// - Results are straight unsigned binary.
`timescale 1ns/100ps
module adcpp_port #(
    parameter int CONV_CYC = adcpp_pkg::CONV_CYC_DEF
) (
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    input  wire logic                         cs_n_pin,
    input  wire logic                         rc_n_pin,
    input  wire logic                         byte_sel_pin,
    input  wire logic [adcpp_pkg::RES_W-1:0]  sample_in,
    output logic                              busy_n_ff,
    output logic                              hold_ff,
    output logic      [adcpp_pkg::LANE_W-1:0] lane_out_ff,
    output logic      [adcpp_pkg::LANE_W-1:0] lane_oe_n_ff
);

    localparam logic [adcpp_pkg::CNT_W-1:0] CONV_LAST =
        adcpp_pkg::CNT_W'(CONV_CYC - 1);
    localparam logic [adcpp_pkg::CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [2:0]                  SYNC_RST = 3'h7;

    // Two-stage synchronisers; the first stage feeds only the second.
    logic [2:0]              sync1_ff;
    logic [2:0]              sync2_ff;
    adcpp_pkg::adcpp_ctl_t   ctl;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end else begin
            sync1_ff <= {cs_n_pin, rc_n_pin, byte_sel_pin};
            sync2_ff <= sync1_ff;
        end
    end

    assign ctl = adcpp_pkg::adcpp_ctl_t'(sync2_ff);

    // Conversion request is a level: both controls low. A level, not an
    // edge, is used so that a request still standing when busy rises
    // starts the next conversion, and either pin may fall first.
    logic req_lvl;
    assign req_lvl = ~(ctl.cs_n | ctl.rc_n);

    // Short glitches are not filtered; the host is trusted to hold the
    // request for the documented minimum, which spans several cycles.

    adcpp_pkg::adcpp_state_t        state_ff;
    adcpp_pkg::adcpp_state_t        nxt_state;
    logic [adcpp_pkg::CNT_W-1:0]    cnt_ff;
    logic [adcpp_pkg::RES_W-1:0]    held_ff;
    logic [adcpp_pkg::RES_W-1:0]    result_ff;
    logic                           done;

    assign done = (state_ff == adcpp_pkg::ADCPP_CONV) && (cnt_ff == CONV_LAST);

    // Next state: any request while converting is ignored.
    always_comb begin
        case (state_ff)
            adcpp_pkg::ADCPP_IDLE: begin
                nxt_state = req_lvl ? adcpp_pkg::ADCPP_CONV : adcpp_pkg::ADCPP_IDLE;
            end
            adcpp_pkg::ADCPP_CONV: begin
                nxt_state = done ? adcpp_pkg::ADCPP_IDLE : adcpp_pkg::ADCPP_CONV;
            end
            default: begin
                nxt_state = adcpp_pkg::ADCPP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= adcpp_pkg::ADCPP_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Conversion timer runs CONV_CYC cycles from the start.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ff <= CNT_ZERO;
        end else if (state_ff == adcpp_pkg::ADCPP_CONV && !done) begin
            cnt_ff <= cnt_ff + 1'b1;
        end else begin
            cnt_ff <= CNT_ZERO;
        end
    end

    // Sample is held at start; the result register updates at the end.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held_ff   <= adcpp_pkg::RES_RST;
            result_ff <= adcpp_pkg::RES_RST;
        end else begin
            if (state_ff == adcpp_pkg::ADCPP_IDLE && req_lvl) begin
                held_ff <= sample_in;
            end
            if (done) begin
                result_ff <= held_ff;
            end
        end
    end

    // Track/hold indicator for the analog core.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= (nxt_state == adcpp_pkg::ADCPP_CONV);
        end
    end

    // Busy falls with the start and rises the cycle the result is stored.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_n_ff <= 1'b1;
        end else begin
            busy_n_ff <= (nxt_state != adcpp_pkg::ADCPP_CONV);
        end
    end

    // Lane data comes from the next result value so that it is on the
    // lanes in the same cycle that busy rises.
    logic [adcpp_pkg::RES_W-1:0]  nxt_result;
    logic [adcpp_pkg::LANE_W-1:0] nxt_lanes;

    assign nxt_result = done ? held_ff : result_ff;

    adcpp_lane_mux u_lane_mux (
        .result   (nxt_result),
        .byte_sel (ctl.byte_sel),
        .lanes    (nxt_lanes)
    );

    // Output enable is a level decode of the two controls, so rising
    // read/convert or falling select both open the lanes.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lane_out_ff  <= adcpp_pkg::LANE_RST;
            lane_oe_n_ff <= ~adcpp_pkg::LANE_RST;
        end else begin
            lane_out_ff  <= nxt_lanes;
            lane_oe_n_ff <= {adcpp_pkg::LANE_W{ctl.cs_n | ~ctl.rc_n}};
        end
    end

endmodule : adcpp_port

// ### sim/adcpp_checker.sv
/* Port assertions for adcpp_port.
   Assumes the bind below; pins reach outputs through three flops. */
`timescale 1ns/100ps
module adcpp_checker #(
    parameter int CONV_CYC = 8
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        cs_n_pin,
    input wire logic        rc_n_pin,
    input wire logic        byte_sel_pin,
    input wire logic        busy_n_ff,
    input wire logic        hold_ff,
    input wire logic [15:0] lane_out_ff,
    input wire logic [15:0] lane_oe_n_ff
);
    logic [2:0]  live_ff;
    logic [15:0] low_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Edges since reset, so $past never looks into the reset.
    always_ff @(posedge clk) begin
        live_ff <= sys_rst ? 3'h0 : (live_ff == 3'h5) ? live_ff : live_ff + 3'h1;
    end
    // Cycles busy has been low.
    always_ff @(posedge clk) begin
        low_ff <= (sys_rst || busy_n_ff) ? 16'h0000 : low_ff + 16'h0001;
    end
    a_oe_decode:
        assert property (live_ff == 3'h5 |-> lane_oe_n_ff ==
            {16{$past(cs_n_pin, 3) | ~$past(rc_n_pin, 3)}}) else $error("oe decode");
    a_hold_track:
        assert property (hold_ff == ~busy_n_ff) else $error("hold");
    a_busy_length:
        assert property ($rose(busy_n_ff) |-> low_ff == 16'(CONV_CYC)) else $error("busy len");
    a_start_cause:
        assert property ($fell(busy_n_ff) |-> $past(~cs_n_pin & ~rc_n_pin, 3))
            else $error("start");
    a_start_dark:
        assert property ($fell(busy_n_ff) |-> &lane_oe_n_ff) else $error("dark");
    // Swapped order zeroes lanes 11..8, word order zeroes lanes 3..0; the lane word
    // was built from the byte select seen three edges back.
    a_zero_fill:
        assert property (live_ff == 3'h5 |-> ($past(byte_sel_pin, 3) ?
            lane_out_ff[11:8] : lane_out_ff[3:0]) == 4'h0) else $error("fill");
    a_lane_hold:
        assert property (live_ff == 3'h5 && $changed(lane_out_ff) |-> $rose(busy_n_ff)
            || $past(byte_sel_pin, 3) != $past(byte_sel_pin, 4)) else $error("lanes");
    a_retrig_gap:
        assert property ($rose(busy_n_ff) |=> busy_n_ff == $past(cs_n_pin | rc_n_pin, 3))
            else $error("retrig");
    c_convert: cover property ($fell(busy_n_ff));
    c_retrig: cover property ($rose(busy_n_ff) ##1 !busy_n_ff);
    c_swap: cover property (!lane_oe_n_ff[0] && byte_sel_pin);
endmodule : adcpp_checker
bind adcpp_port adcpp_checker #(.CONV_CYC(CONV_CYC)) adcpp_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .rc_n_pin(rc_n_pin),
    .byte_sel_pin(byte_sel_pin), .busy_n_ff(busy_n_ff), .hold_ff(hold_ff),
    .lane_out_ff(lane_out_ff), .lane_oe_n_ff(lane_oe_n_ff));

// ### sim/adcpp_host_model.sv
/* Host model driving the control pins of adcpp_port.
   Assumes callers run in a process tied to clk. */
`timescale 1ns/100ps
module adcpp_host_model (
    input  wire logic clk,
    output logic      cs_n,
    output logic      rc_n,
    output logic      byte_sel
);
    // Idle deselected and in read mode.
    initial begin
        cs_n = 1'b1;
        rc_n = 1'b1;
        byte_sel = 1'b0;
    end
    // Pins change just after a falling edge, away from sampling.
    task automatic pins(input logic cs, input logic rc, input logic bs);
        @(negedge clk);
        cs_n = cs;
        rc_n = rc;
        byte_sel = bs;
    endtask : pins
    // Release before busy ends, or a stale sample is converted again.
    task automatic request;
        pins(1'b0, 1'b0, byte_sel);
        repeat (10) @(negedge clk);
        rc_n = 1'b1;
    endtask : request
endmodule : adcpp_host_model

// ### sim/tb_adcpp_port.sv
/* Self-checking bench for adcpp_port.
   Assumes a shortened conversion of 40 cycles. */
`timescale 1ns/100ps
module tb_adcpp_port;
    logic        clk = 1'b0;
    logic        sys_rst;
    logic [11:0] smp = 12'h000;
    logic        busy_n;
    logic [15:0] lanes;
    logic [15:0] oe_n;
    logic        cs_n;
    logic        rc_n;
    logic        bsel;
    int          err_total = 0;
    int          compares = 0;
    logic [11:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
    adcpp_port #(.CONV_CYC(40)) adcpp_port_inst (.clk(clk), .sys_rst(sys_rst),
        .cs_n_pin(cs_n), .rc_n_pin(rc_n), .byte_sel_pin(bsel), .sample_in(smp),
        .busy_n_ff(busy_n), .hold_ff(), .lane_out_ff(lanes), .lane_oe_n_ff(oe_n));
    adcpp_host_model adcpp_host_model_inst (.clk(clk), .cs_n(cs_n), .rc_n(rc_n),
        .byte_sel(bsel));
    always #2 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic pins(input logic cs, input logic rc);
        adcpp_host_model_inst.pins(cs, rc, 1'b0);
    endtask : pins
    // Bounded wait for busy to go high.
    task automatic wait_ready;
        for (int n = 0; n < 200 && busy_n !== 1'b1; n++) @(negedge clk);
        check({15'h0, busy_n}, 16'h0001);
    endtask : wait_ready
    task automatic t_codes;
        foreach (codes[i]) begin
            smp = codes[i];
            adcpp_host_model_inst.request();
            wait_ready();
            check(lanes, {codes[i], 4'h0});
            check(oe_n, 16'h0000);
        end
        adcpp_host_model_inst.pins(1'b0, 1'b1, 1'b1);
        repeat (5) @(negedge clk);
        check(lanes, {codes[4][3:0], 4'h0, codes[4][11:4]});
        $display("t_codes done");
    endtask : t_codes
    task automatic t_pins;
        pins(1'b1, 1'b1);
        repeat (5) @(negedge clk);
        check(oe_n, 16'hFFFF);
        pins(1'b0, 1'b1);
        repeat (5) @(negedge clk);
        check({oe_n[15:1], busy_n}, 16'h0001);
        pins(1'b1, 1'b0);
        repeat (5) @(negedge clk);
        check({oe_n[15:1], busy_n}, 16'hFFFF);
        pins(1'b0, 1'b0);
        repeat (10) @(negedge clk);
        check({oe_n[15:1], busy_n}, 16'hFFFE);
        pins(1'b0, 1'b1);
        adcpp_host_model_inst.request();
        wait_ready();
        repeat (6) @(negedge clk);
        check({15'h0, busy_n}, 16'h0001);
        pins(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        wait_ready();
        @(negedge clk);
        check({15'h0, busy_n}, 16'h0000);
        pins(1'b0, 1'b1);
        wait_ready();
        $display("t_pins done");
    endtask : t_pins
    initial begin
        sys_rst = 1'b1;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        t_codes();
        t_pins();
        print_verdict();
    end
    // Both tests need well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule : tb_adcpp_port
